/* verilog/otgtm_cfg.svh */
// constants of the on-the-go timers and event enables: command codes, fields, timing
`ifndef OTGTM_CFG_SVH
`define OTGTM_CFG_SVH

// command codes: read codes have bit 7 clear, write codes have it set
`define OTGTM_CMD_RD_EVENT 8'h68
`define OTGTM_CMD_WR_EVENT 8'hE8
`define OTGTM_CMD_RD_IEN 8'h69
`define OTGTM_CMD_WR_IEN 8'hE9
`define OTGTM_CMD_RD_CDT 8'h6A
`define OTGTM_CMD_WR_CDT 8'hEA
`define OTGTM_CMD_RD_ELT 8'h6C
`define OTGTM_CMD_WR_ELT 8'hEC

// field positions
`define OTGTM_RUN_BIT 31
`define OTGTM_VAL_MSB 23
`define OTGTM_NUM_STATUS 7
`define OTGTM_TMR_FLAG_BIT 10
`define OTGTM_BIT_SUSPEND 6
`define OTGTM_BIT_REMOTE_CONNECT_STATUS 5
`define OTGTM_BIT_B_SESSION_VALID 4
`define OTGTM_BIT_A_SESSION_VALID 3
`define OTGTM_BIT_B_SESSION_END 2
`define OTGTM_BIT_A_VBUS_VALID 1
`define OTGTM_BIT_ID_PIN 0

// implemented bits of the enable and event registers (bits 6..0 and 10)
`define OTGTM_EVT_MASK 16'h047F

// reset values
`define OTGTM_RST_16 16'h0000
`define OTGTM_RST_24 24'h000000

// counter limits
`define OTGTM_CNT_FULL 24'hFFFFFF
`define OTGTM_CNT_NEAR_FULL 24'hFFFFFE
`define OTGTM_CNT_ONE 24'h000001

// timing: one tick is 0.01 ms, the core clock period is 8 ns
`define OTGTM_TICK_NS 10000
`define OTGTM_CLK_NS 8
`define OTGTM_TICK_CYCLES ((`OTGTM_TICK_NS) / (`OTGTM_CLK_NS))
`define OTGTM_TICK_CW 11

`endif

/* verilog/otgtm_pkg.sv */
// state types of the on-the-go timer block
`include "otgtm_cfg.svh"

package otgtm_pkg;

  // tick prescaler state
  typedef struct packed {
    logic [`OTGTM_TICK_CW-1:0] cnt;
    logic tick;
  } otgtm_presc_t;

  // status synchroniser and change detector state
  typedef struct packed {
    logic [`OTGTM_NUM_STATUS-1:0] s1;
    logic [`OTGTM_NUM_STATUS-1:0] s2;
    logic [`OTGTM_NUM_STATUS-1:0] s3;
    logic [`OTGTM_NUM_STATUS-1:0] stable;
    logic [1:0] fill;
    logic [`OTGTM_NUM_STATUS-1:0] chg;
  } otgtm_sync_t;

  // main block state
  typedef struct packed {
    logic [15:0] ien;
    logic [15:0] flags;
    logic cdt_run;
    logic [23:0] cdt_load;
    logic [23:0] cdt_cnt;
    logic elt_run;
    logic [23:0] elt_cnt;
    logic [31:0] rdata;
    logic rvalid;
    logic irq;
  } otgtm_state_t;

endpackage

/* verilog/otgtm_tick_gen.sv */
// prescaler that makes the shared ten-microsecond tick from the core clock
`timescale 1ns/1ns
`include "otgtm_cfg.svh"

module otgtm_tick_gen #(
  parameter int unsigned DIV = `OTGTM_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);

  otgtm_pkg::otgtm_presc_t st_r;
  otgtm_pkg::otgtm_presc_t st_nxt;

  // free-running divider, one-cycle tick at the end of each period
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt == `OTGTM_TICK_CW'(DIV - 1)) begin
      st_nxt.cnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + `OTGTM_TICK_CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule

/* verilog/otgtm_status_sync.sv */
// three-stage synchroniser and change detector for the on-the-go status levels
`timescale 1ns/1ns
`include "otgtm_cfg.svh"

module otgtm_status_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`OTGTM_NUM_STATUS-1:0] level_in,
  output logic [`OTGTM_NUM_STATUS-1:0] change
);

  otgtm_pkg::otgtm_sync_t st_r;
  otgtm_pkg::otgtm_sync_t st_nxt;

  // a level counts once stages two and three agree; stage one feeds stage two only
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = level_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.chg = '0;
    if (st_r.fill != 2'h3) begin
      // pipeline still holds reset zeros: seed the level, so a pin that idles
      // high does not look like an edge just after reset
      st_nxt.fill = st_r.fill + 2'h1;
      st_nxt.stable = st_r.s2;
    end else begin
      for (int i = 0; i < `OTGTM_NUM_STATUS; i++) begin
        if (st_r.s2[i] == st_r.s3[i]) begin
          st_nxt.stable[i] = st_r.s3[i];
          if (st_r.s3[i] != st_r.stable[i]) begin
            st_nxt.chg[i] = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign change = st_r.chg;

endmodule

/* verilog/otgtm_top.sv */
// on-the-go event enables, one-shot countdown timer and elapsed-time counter
//
// Notes on behaviour
// - suspend-change enable bit gates the bus suspend change interrupt.
// - remote-connect enable bit gates the remote-connection change interrupt.
// - enables 4..0 gate session, vbus and id-pin change interrupts.
// - writing run bit 1 loads the initial value and starts counting.
// - writing run bit 0 halts the countdown at once, no time-out.
// - on time-out the countdown run bit clears itself.
// - countdown initial value is a 24-bit read-write field, bits 23..0.
// - each countdown count is one 0.01 ms tick.
// - writing run bit 1 starts the elapsed counter from zero.
// - at all-ones the elapsed counter clears its run bit, no wrap.
// - writing run bit 0 stops the elapsed counter.
// - any enabled pending event stops the elapsed counter, keeping its count.
// - elapsed register bits 23..0 are read-only and return the count.
// - elapsed counter advances once per 0.01 ms tick.
// - enable bit 10 gates the countdown time-out interrupt.
// - event flags clear on writing 1, writing 0 leaves them.
`timescale 1ns/1ns
`include "otgtm_cfg.svh"

module otgtm_top #(
  parameter int unsigned TICK_DIV = `OTGTM_TICK_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [7:0] CMD_CODE,
  input wire logic CMD_WR,
  input wire logic CMD_RD,
  input wire logic [31:0] CMD_WDATA,
  output logic [31:0] CMD_RDATA,
  output logic CMD_RVALID,
  input wire logic BUS_SUSPEND,
  input wire logic REMOTE_CONNECT_STATUS,
  input wire logic B_SESSION_VALID,
  input wire logic A_SESSION_VALID,
  input wire logic B_SESSION_END,
  input wire logic A_VBUS_VALID,
  input wire logic ID_PIN_STATE,
  output logic OTG_IRQ
);

  otgtm_pkg::otgtm_state_t st_r;
  otgtm_pkg::otgtm_state_t st_nxt;

  logic tick;
  logic [`OTGTM_NUM_STATUS-1:0] status_lvl;
  logic [`OTGTM_NUM_STATUS-1:0] status_chg;

  // status levels in event-bit order
  always_comb begin
    status_lvl = '0;
    status_lvl[`OTGTM_BIT_SUSPEND] = BUS_SUSPEND;
    status_lvl[`OTGTM_BIT_REMOTE_CONNECT_STATUS] = REMOTE_CONNECT_STATUS;
    status_lvl[`OTGTM_BIT_B_SESSION_VALID] = B_SESSION_VALID;
    status_lvl[`OTGTM_BIT_A_SESSION_VALID] = A_SESSION_VALID;
    status_lvl[`OTGTM_BIT_B_SESSION_END] = B_SESSION_END;
    status_lvl[`OTGTM_BIT_A_VBUS_VALID] = A_VBUS_VALID;
    status_lvl[`OTGTM_BIT_ID_PIN] = ID_PIN_STATE;
  end

  // status pins are asynchronous to the core clock
  otgtm_status_sync u_sync (
    .clk(CORE_CLK),
    .rst(RST),
    .level_in(status_lvl),
    .change(status_chg)
  );

  // shared tick; free running, so the first count after a start lands anywhere
  // within one tick period, an error of at most 0.01 ms
  otgtm_tick_gen #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clk(CORE_CLK),
    .rst(RST),
    .tick(tick)
  );

  // command decode
  logic wr_evt;
  logic wr_ien;
  logic wr_cdt;
  logic wr_elt;
  logic [15:0] evt_set;
  logic [15:0] evt_clr;
  logic evt_hit;
  logic timeout;

  always_comb begin
    wr_evt = CMD_WR && (CMD_CODE == `OTGTM_CMD_WR_EVENT);
    wr_ien = CMD_WR && (CMD_CODE == `OTGTM_CMD_WR_IEN);
    wr_cdt = CMD_WR && (CMD_CODE == `OTGTM_CMD_WR_CDT);
    wr_elt = CMD_WR && (CMD_CODE == `OTGTM_CMD_WR_ELT);
  end

  // next-state logic for all registers of the block
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    timeout = 1'b0;
    evt_set = '0;
    evt_clr = '0;

    // enable register: only bits 6..0 and 10 exist, the rest read zero
    if (wr_ien) begin
      st_nxt.ien = CMD_WDATA[15:0] & `OTGTM_EVT_MASK;
    end

    // countdown timer; a write always wins over a tick in the same cycle
    if (wr_cdt) begin
      st_nxt.cdt_load = CMD_WDATA[`OTGTM_VAL_MSB:0];
      st_nxt.cdt_run = CMD_WDATA[`OTGTM_RUN_BIT];
      if (CMD_WDATA[`OTGTM_RUN_BIT]) begin
        st_nxt.cdt_cnt = CMD_WDATA[`OTGTM_VAL_MSB:0];
      end
      // a stop write drops the run bit and never reports time-out
    end else if (st_r.cdt_run && tick) begin
      if (st_r.cdt_cnt <= `OTGTM_CNT_ONE) begin
        // a load of zero or one expires on the first tick
        st_nxt.cdt_cnt = `OTGTM_RST_24;
        st_nxt.cdt_run = 1'b0;
        timeout = 1'b1;
      end else begin
        st_nxt.cdt_cnt = st_r.cdt_cnt - `OTGTM_CNT_ONE;
      end
    end

    // event flags: hardware set wins over a software clear in the same cycle
    evt_set[`OTGTM_NUM_STATUS-1:0] = status_chg;
    evt_set[`OTGTM_TMR_FLAG_BIT] = timeout;
    if (wr_evt) begin
      evt_clr = CMD_WDATA[15:0];
    end
    st_nxt.flags = ((st_r.flags & ~evt_clr) | evt_set) & `OTGTM_EVT_MASK;

    // elapsed counter; pending enabled events are judged on registered state
    evt_hit = |(st_r.flags & st_r.ien);
    if (wr_elt) begin
      st_nxt.elt_run = CMD_WDATA[`OTGTM_RUN_BIT];
      if (CMD_WDATA[`OTGTM_RUN_BIT]) begin
        st_nxt.elt_cnt = `OTGTM_RST_24;
      end
    end else if (st_r.elt_run && evt_hit) begin
      // count is frozen, so the read-back field holds the captured value
      st_nxt.elt_run = 1'b0;
    end else if (st_r.elt_run && tick) begin
      st_nxt.elt_cnt = st_r.elt_cnt + `OTGTM_CNT_ONE;
      if (st_r.elt_cnt == `OTGTM_CNT_NEAR_FULL) begin
        st_nxt.elt_run = 1'b0;
      end
    end else if (st_r.elt_run && (st_r.elt_cnt == `OTGTM_CNT_FULL)) begin
      st_nxt.elt_run = 1'b0;
    end

    // interrupt request follows the gated flags of the next state
    st_nxt.irq = |(st_nxt.flags & st_nxt.ien);

    // read port: data one cycle after the strobe, unknown codes return zero
    if (CMD_RD) begin
      st_nxt.rvalid = 1'b1;
      case (CMD_CODE)
        `OTGTM_CMD_RD_EVENT: begin
          st_nxt.rdata = {16'h0000, st_r.flags};
        end
        `OTGTM_CMD_RD_IEN: begin
          st_nxt.rdata = {16'h0000, st_r.ien};
        end
        `OTGTM_CMD_RD_CDT: begin
          st_nxt.rdata = {st_r.cdt_run, 7'h00, st_r.cdt_load};
        end
        `OTGTM_CMD_RD_ELT: begin
          st_nxt.rdata = {st_r.elt_run, 7'h00, st_r.elt_cnt};
        end
        default: begin
          st_nxt.rdata = 32'h00000000;
        end
      endcase
    end
  end

  // single state register; reset clears run bits, counters and enables
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign CMD_RDATA = st_r.rdata;
  assign CMD_RVALID = st_r.rvalid;
  assign OTG_IRQ = st_r.irq;

endmodule

/* tb/otgtm_props.sv */
// port checker of the on-the-go timer block
`timescale 1ns/1ns
module otgtm_props (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [7:0] CMD_CODE,
  input wire logic CMD_WR,
  input wire logic CMD_RD,
  input wire logic [31:0] CMD_WDATA,
  input wire logic [31:0] CMD_RDATA,
  input wire logic CMD_RVALID,
  input wire logic OTG_IRQ
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  // command port answers
  AST_RD_ANSWER: assert property (CMD_RD |=> CMD_RVALID)
    else $error("read not answered");
  AST_NO_STRAY: assert property (!CMD_RD |=> !CMD_RVALID)
    else $error("stray read valid");
  AST_UNKNOWN_RD: assert property (CMD_RD && !(CMD_CODE inside {8'h68, 8'h69, 8'h6A, 8'h6C})
    |=> CMD_RDATA == 32'h00000000) else $error("unknown code read not zero");
  // load value survives, reserved bits read zero
  AST_LOAD_RW: assert property (CMD_WR && CMD_CODE == 8'hEA ##1 !CMD_WR ##1
    CMD_RD && CMD_CODE == 8'h6A |=> CMD_RDATA[23:0] == $past(CMD_WDATA[23:0], 3))
    else $error("load value lost");
  AST_RSV_ZERO: assert property (CMD_RD && CMD_CODE inside {8'h6A, 8'h6C}
    |=> CMD_RDATA[30:24] == 7'h00) else $error("timer reserved bits set");
  AST_EVT_BITS: assert property (CMD_RD && CMD_CODE inside {8'h68, 8'h69}
    |=> (CMD_RDATA & ~32'h0000047F) == 32'h00000000) else $error("event reserved bits set");
  // elapsed counter run bit follows writes
  AST_ELT_STOP: assert property (CMD_WR && CMD_CODE == 8'hEC && !CMD_WDATA[31] ##1 !CMD_WR
    ##1 CMD_RD && CMD_CODE == 8'h6C |=> !CMD_RDATA[31]) else $error("elapsed did not stop");
  // a pending enabled event may stop it at once, so only a quiet request counts
  AST_ELT_START: assert property (CMD_WR && CMD_CODE == 8'hEC && CMD_WDATA[31] ##1 !CMD_WR
    && !OTG_IRQ
    ##1 CMD_RD && CMD_CODE == 8'h6C |=> CMD_RDATA[31] && CMD_RDATA[23:0] <= 24'h000001)
    else $error("elapsed did not start from zero");
  // all enables off silences the request on the next edge
  AST_IRQ_MASKED: assert property (CMD_WR && CMD_CODE == 8'hE9
    && (CMD_WDATA[15:0] & 16'h047F) == 16'h0000 |=> !OTG_IRQ) else $error("masked irq high");
  AST_RST_CLEAR: assert property ($fell(RST) |-> CMD_RDATA == 32'h00000000
    && !CMD_RVALID && !OTG_IRQ) else $error("outputs not cleared by reset");
endmodule

bind otgtm_top otgtm_props u_otgtm_props (.CORE_CLK(CORE_CLK), .RST(RST), .CMD_CODE(CMD_CODE),
  .CMD_WR(CMD_WR), .CMD_RD(CMD_RD), .CMD_WDATA(CMD_WDATA), .CMD_RDATA(CMD_RDATA),
  .CMD_RVALID(CMD_RVALID), .OTG_IRQ(OTG_IRQ));

/* tb/otgtm_top_tb.sv */
// self-checking bench of the on-the-go timer block
`timescale 1ns/1ns
module otgtm_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] code = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [6:0] st = 7'h00;
  logic [31:0] rdata;
  logic [31:0] v;
  logic rvalid;
  logic irq;
  int n_fail = 0;
  int checked = 0;

  // short tick so countdowns finish in tens of cycles
  otgtm_top #(.TICK_DIV(4)) u_otgtm_top (.CORE_CLK(clk), .RST(rst), .CMD_CODE(code),
    .CMD_WR(wr), .CMD_RD(rd), .CMD_WDATA(wdata), .CMD_RDATA(rdata), .CMD_RVALID(rvalid),
    .BUS_SUSPEND(st[6]), .REMOTE_CONNECT_STATUS(st[5]), .B_SESSION_VALID(st[4]),
    .A_SESSION_VALID(st[3]), .B_SESSION_END(st[2]), .A_VBUS_VALID(st[1]),
    .ID_PIN_STATE(st[0]), .OTG_IRQ(irq));

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // one-cycle strobes; an idle edge between calls keeps strobes single-assigned
  task automatic wr_cmd(logic [7:0] c, logic [31:0] d);
    @(posedge clk);
    code <= c;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_cmd(logic [7:0] c, output logic [31:0] g);
    @(posedge clk);
    code <= c;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rvalid", 32'h00000001, {31'h0, rvalid});
    g = rdata;
  endtask

  task automatic rd_exp(logic [7:0] c, logic [31:0] e);
    logic [31:0] g;
    rd_cmd(c, g);
    chk("rdata", e, g);
  endtask

  task automatic irq_is(int n, logic e);
    repeat (n) @(posedge clk);
    #1;
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  task automatic report_and_stop;
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // whole run is well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // the status synchroniser primes itself first
    repeat (4) @(posedge clk);
    rd_exp(8'h68, 32'h00000000);
    rd_exp(8'h6A, 32'h00000000);
    rd_exp(8'h6C, 32'h00000000);
    rd_exp(8'h6B, 32'h00000000);
    wr_cmd(8'hE9, 32'h0000FFFF);
    rd_exp(8'h69, 32'h0000047F);
    wr_cmd(8'hE9, 32'h00000000);
    // each status change: masked, then enabled, then cleared
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      st[i] <= ~st[i];
      irq_is(8, 1'b0);
      rd_exp(8'h68, 32'h00000001 << i);
      wr_cmd(8'hE9, 32'h00000001 << i);
      irq_is(2, 1'b1);
      wr_cmd(8'hE8, 32'h00000000);
      rd_exp(8'h68, 32'h00000001 << i);
      wr_cmd(8'hE8, 32'h00000001 << i);
      irq_is(2, 1'b0);
      wr_cmd(8'hE9, 32'h00000000);
    end
    // countdown of three ticks
    wr_cmd(8'hE9, 32'h00000400);
    wr_cmd(8'hEA, 32'h80000003);
    rd_exp(8'h6A, 32'h80000003);
    repeat (4) @(posedge clk);
    rd_exp(8'h68, 32'h00000000);
    repeat (12) @(posedge clk);
    rd_exp(8'h6A, 32'h00000003);
    rd_exp(8'h68, 32'h00000400);
    irq_is(0, 1'b1);
    wr_cmd(8'hE8, 32'h00000400);
    // stop before time-out
    wr_cmd(8'hEA, 32'h80000002);
    wr_cmd(8'hEA, 32'h00000002);
    repeat (20) @(posedge clk);
    rd_exp(8'h68, 32'h00000000);
    // elapsed counter: start, stop, low bits ignored on write
    wr_cmd(8'hEC, 32'h80000000);
    rd_cmd(8'h6C, v);
    chk("elt start", 32'h80000000, v & 32'h80FFFFFE);
    repeat (38) @(posedge clk);
    wr_cmd(8'hEC, 32'h00FFFFFF);
    rd_cmd(8'h6C, v);
    chk("elt run", 32'h00000000, {31'h0, v[31]});
    chk("elt span", 32'h00000001, {31'h0, v[23:0] inside {[24'h00000A:24'h00000B]}});
    // an enabled event freezes the elapsed count
    wr_cmd(8'hE9, 32'h00000001);
    wr_cmd(8'hEC, 32'h80000000);
    repeat (16) @(posedge clk);
    st[0] <= ~st[0];
    repeat (20) @(posedge clk);
    rd_cmd(8'h6C, v);
    chk("elt evt run", 32'h00000000, {31'h0, v[31]});
    chk("elt evt span", 32'h00000001, {31'h0, v[23:0] inside {[24'h000004:24'h000006]}});
    wr_cmd(8'hE8, 32'h00000001);
    wr_cmd(8'hE9, 32'h00000000);
    report_and_stop();
  end
endmodule
